// *** src/nsx_map.svh ***
// Opcode patterns, field positions and constants for the swap/test/xor datapath
`ifndef NSX_MAP_SVH
`define NSX_MAP_SVH
`define NSX_OP_SWAPW_PAT   16'h3800
`define NSX_OP_SWAPW_MASK  16'hFE00
`define NSX_OP_TEST_PAT    16'h2200
`define NSX_OP_TEST_MASK   16'hFE00
`define NSX_OP_XORF_PAT    16'h1A00
`define NSX_OP_XORF_MASK   16'hFE00
`define NSX_OP_XORW_PAT    16'h1800
`define NSX_OP_XORW_MASK   16'hFE00
`define NSX_OP_XORL_PAT    16'h7F00
`define NSX_OP_XORL_MASK   16'hFF00
`define NSX_ADDR_MSB       8
`define NSX_LIT_MSB        7
`define NSX_ACC_RST        8'h00
`define NSX_ZERO_RST       1'b0
`define NSX_BYTE_ZERO      8'h00
`define NSX_T0_COUNT_ADDR  9'h000
`endif

// *** src/nsx_pkg.sv ***
// Types shared by the swap/test/xor datapath
`default_nettype none
package nsx_pkg;
    typedef enum logic [2:0] {
        NSX_NONE  = 3'b000,
        NSX_SWAPW = 3'b001,
        NSX_TEST  = 3'b011,
        NSX_XORF  = 3'b010,
        NSX_XORW  = 3'b110,
        NSX_XORL  = 3'b111
    } nsx_op_t;
    typedef struct packed {
        logic        we;
        logic [8:0]  addr;
        logic [7:0]  data;
    } nsx_mem_wr_t;
endpackage : nsx_pkg
`default_nettype wire

// *** src/nsx_alu.sv ***
// Single-cycle execution datapath for nibble swap, zero test and exclusive OR
`timescale 1ns/1ps
`default_nettype none
`include "nsx_map.svh"
module nsx_alu (
    input  wire logic              ref_clk_in,           // Core clock, 250 MHz
    input  wire logic              sys_rst_in,           // Synchronous reset, active high
    input  wire logic              op_valid_in,          // Decoded opcode present this cycle
    input  wire logic [15:0]       opcode_in,            // Opcode from fetch/decode
    input  wire logic [7:0]        mem_rdata_in,         // Data read at mem_addr_out
    input  wire logic              t0_expire_in,         // Prescaler about to expire
    output logic [8:0]             mem_addr_out,         // Operand address (combinational)
    output nsx_pkg::nsx_mem_wr_t   mem_wr_out,           // Registered data memory write
    output logic [7:0]             acc_out,              // Accumulator
    output logic                   zero_flag_out,        // Zero status flag
    output logic                   t0_presc_clr_out,     // Prescaler reset pulse
    output logic                   t0_inc_block_out,     // Suppress timer increment
    output logic                   op_hit_out            // Opcode belongs to this block
);
    import nsx_pkg::*;

    // Pattern match used by all five decodes
    function automatic logic op_match(input logic [15:0] op, input logic [15:0] pat,
                                      input logic [15:0] mask);
        op_match = ((op & mask) == pat);
    endfunction : op_match

    // Zero detect shared by test and xor paths
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == `NSX_BYTE_ZERO);
    endfunction : is_zero

    nsx_op_t     op_sel;          // Decoded operation
    logic [8:0]  operand_addr;    // Data memory operand address
    logic [7:0]  immediate_byte;  // Literal byte
    logic [7:0]  swap_val;        // Nibble-swapped operand
    logic [7:0]  xor_mem_val;     // Operand xor accumulator
    logic [7:0]  xor_lit_val;     // Immediate xor accumulator
    logic [7:0]  acc_r;           // Accumulator register
    logic [7:0]  acc_nxt;         // Accumulator next value
    logic        zero_r;          // Zero flag register
    logic        zero_nxt;        // Zero flag next value
    nsx_mem_wr_t wr_r;            // Write port register
    nsx_mem_wr_t wr_nxt;          // Write port next value
    logic        t0_hit;          // Test aimed at timer count

    // Operand fields straight from the opcode
    assign operand_addr   = opcode_in[`NSX_ADDR_MSB:0];
    assign immediate_byte = opcode_in[`NSX_LIT_MSB:0];
    assign mem_addr_out   = operand_addr;

    // Decode; only valid opcodes select an operation
    assign op_sel = !op_valid_in ? NSX_NONE :
        op_match(opcode_in, `NSX_OP_SWAPW_PAT, `NSX_OP_SWAPW_MASK) ? NSX_SWAPW :
        op_match(opcode_in, `NSX_OP_TEST_PAT,  `NSX_OP_TEST_MASK)  ? NSX_TEST  :
        op_match(opcode_in, `NSX_OP_XORF_PAT,  `NSX_OP_XORF_MASK)  ? NSX_XORF  :
        op_match(opcode_in, `NSX_OP_XORW_PAT,  `NSX_OP_XORW_MASK)  ? NSX_XORW  :
        op_match(opcode_in, `NSX_OP_XORL_PAT,  `NSX_OP_XORL_MASK)  ? NSX_XORL  :
        NSX_NONE;
    assign op_hit_out = (op_sel != NSX_NONE);

    // Datapath results
    assign swap_val    = {mem_rdata_in[3:0], mem_rdata_in[7:4]};
    assign xor_mem_val = mem_rdata_in ^ acc_r;
    assign xor_lit_val = immediate_byte ^ acc_r;

    // Timer side effects are combinational so they hit the same cycle
    assign t0_hit           = (op_sel == NSX_TEST) && (operand_addr == `NSX_T0_COUNT_ADDR);
    assign t0_presc_clr_out = t0_hit;
    assign t0_inc_block_out = t0_hit && t0_expire_in;

    // Next-state selection per operation
    always_comb begin
        acc_nxt  = acc_r;
        zero_nxt = zero_r;
        wr_nxt   = '0; // Idle port shows zeros, never stale operands
        case (op_sel)
            NSX_SWAPW: begin
                acc_nxt = swap_val;
            end
            NSX_TEST: begin
                // Write back the value read: no net change
                wr_nxt.we   = 1'b1;
                wr_nxt.addr = operand_addr;
                wr_nxt.data = mem_rdata_in;
                zero_nxt  = is_zero(mem_rdata_in);
            end
            NSX_XORF: begin
                wr_nxt.we   = 1'b1;
                wr_nxt.addr = operand_addr;
                wr_nxt.data = xor_mem_val;
                zero_nxt    = is_zero(xor_mem_val);
            end
            NSX_XORW: begin
                acc_nxt  = xor_mem_val;
                zero_nxt = is_zero(xor_mem_val);
            end
            NSX_XORL: begin
                acc_nxt  = xor_lit_val;
                zero_nxt = is_zero(xor_lit_val);
            end
            default: begin
                acc_nxt = acc_r; // Not ours: hold state
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            acc_r  <= `NSX_ACC_RST;
            zero_r <= `NSX_ZERO_RST;
            wr_r   <= '0;
        end else begin
            acc_r  <= acc_nxt;
            zero_r <= zero_nxt;
            wr_r   <= wr_nxt;
        end
    end

    assign acc_out       = acc_r;
    assign zero_flag_out = zero_r;
    assign mem_wr_out    = wr_r;

    // Checks: most look one edge after the op, where its registered result stands

    // Swap places the exchanged nibbles in the accumulator
    chk_swap_acc: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_SWAPW |=> acc_r == {$past(mem_rdata_in[3:0]), $past(mem_rdata_in[7:4])})
        else $error("swap result wrong");

    // Swap writes nothing and leaves the zero flag alone
    chk_swap_quiet: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_SWAPW |=> !wr_r.we && $stable(zero_r))
        else $error("swap touched memory or flag");

    // Test writes back exactly the value read and keeps the accumulator
    chk_test_wb: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_TEST |=> wr_r.we && wr_r.data == $past(mem_rdata_in) && $stable(acc_r))
        else $error("test write-back wrong");

    // Test write-back goes to the tested location
    chk_test_addr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_TEST |=> wr_r.addr == $past(opcode_in[`NSX_ADDR_MSB:0]))
        else $error("test write address wrong");

    // Test sets zero exactly when the location holds zero
    chk_test_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_TEST |=> zero_r == ($past(mem_rdata_in) == 8'h00))
        else $error("test zero flag wrong");

    // Prescaler clear follows the raw opcode, independent of the decode chain
    chk_t0_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        t0_presc_clr_out == (op_valid_in
            && ((opcode_in & `NSX_OP_TEST_MASK) == `NSX_OP_TEST_PAT)
            && opcode_in[`NSX_ADDR_MSB:0] == `NSX_T0_COUNT_ADDR))
        else $error("prescaler clear wrong");

    // No prescaler clear from any other operation
    chk_t0_other: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel != NSX_TEST |-> !t0_presc_clr_out)
        else $error("prescaler cleared outside a test");

    // A pending increment that meets the clear is suppressed
    chk_t0_block: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        t0_presc_clr_out && t0_expire_in |-> t0_inc_block_out)
        else $error("timer increment not suppressed");

    // Suppression never happens without both the clear and a pending increment
    chk_t0_only: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        t0_inc_block_out |-> t0_presc_clr_out && t0_expire_in)
        else $error("timer increment suppressed without cause");

    // Xor into memory writes the result and keeps the accumulator
    chk_xorf_mem: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_XORF |=> wr_r.we && wr_r.data == ($past(mem_rdata_in) ^ $past(acc_r))
            && $stable(acc_r))
        else $error("xor to memory wrong");

    // Xor into memory flags a zero result
    chk_xorf_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_XORF |=> zero_r == (wr_r.data == `NSX_BYTE_ZERO))
        else $error("xor to memory zero flag wrong");

    // Xor into the accumulator leaves memory untouched
    chk_xorw_acc: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_XORW |=> !wr_r.we && acc_r == ($past(mem_rdata_in) ^ $past(acc_r)))
        else $error("xor to accumulator wrong");

    // Xor into the accumulator clears zero on a nonzero result
    chk_xorw_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_XORW |=> zero_r == (acc_r == `NSX_BYTE_ZERO))
        else $error("xor to accumulator zero flag wrong");

    // Xor with the immediate byte lands in the accumulator
    chk_xorl_acc: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_XORL |=> acc_r == ($past(opcode_in[7:0]) ^ $past(acc_r)))
        else $error("xor immediate wrong");

    // Xor with the immediate byte flags a zero result
    chk_xorl_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_XORL |=> zero_r == (acc_r == 8'h00))
        else $error("xor zero flag wrong");

    // Xor with the immediate byte never writes memory
    chk_xorl_quiet: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_XORL |=> !wr_r.we)
        else $error("xor immediate wrote memory");

    // Opcodes that are not ours, or not valid, change nothing
    chk_idle_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        op_sel == NSX_NONE |=> !wr_r.we && $stable(acc_r) && $stable(zero_r))
        else $error("foreign opcode changed state");
endmodule : nsx_alu
`default_nettype wire

// *** verif/nsx_mem_model.sv ***
// Data memory model answering the datapath's combinational read port
`timescale 1ns/1ps
`default_nettype none
module nsx_mem_model (
    input  wire logic                 clk_in,    // Core clock
    input  wire logic [8:0]           addr_in,   // Read address
    input  wire nsx_pkg::nsx_mem_wr_t wr_in,     // Registered write port
    output logic [7:0]                rdata_out  // Read data, same cycle
);
    import nsx_pkg::*;
    logic [7:0] mem [512];  // Storage, seeded with a known pattern
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'(i * 8'h35);
        end
    end
    // Writes land one cycle after the op, so a pending write is forwarded
    assign rdata_out = (wr_in.we && wr_in.addr == addr_in) ? wr_in.data : mem[addr_in];
    // Commit the write at the edge
    always @(posedge clk_in) begin
        if (wr_in.we) begin
            mem[wr_in.addr] <= wr_in.data;
        end
    end
endmodule : nsx_mem_model
`default_nettype wire

// *** verif/tb.sv ***
// Random self-checking bench for the swap/test/xor datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nsx_pkg::*;
    logic        ref_clk_in, sys_rst_in, op_valid_in, t0_expire_in;
    logic [15:0] opcode_in;
    logic [7:0]  mem_rdata_in, acc_out, acc_m, v, lit;
    logic [8:0]  mem_addr_out, a;
    logic        zero_flag_out, t0_presc_clr_out, t0_inc_block_out, op_hit_out, z_m, vld;
    nsx_mem_wr_t mem_wr_out, wr_m;
    logic [7:0]  ref_mem [512];  // Architectural memory of the reference
    int          errors, checked, k;
    nsx_alu u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in),
        .opcode_in(opcode_in), .mem_rdata_in(mem_rdata_in), .t0_expire_in(t0_expire_in),
        .mem_addr_out(mem_addr_out), .mem_wr_out(mem_wr_out), .acc_out(acc_out),
        .zero_flag_out(zero_flag_out), .t0_presc_clr_out(t0_presc_clr_out),
        .t0_inc_block_out(t0_inc_block_out), .op_hit_out(op_hit_out));
    nsx_mem_model u_mem (.clk_in(ref_clk_in), .addr_in(mem_addr_out), .wr_in(mem_wr_out),
        .rdata_out(mem_rdata_in));
    // Clock, 4 ns period
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    // Compare one value and count it
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Verdict and end of run
    task automatic conclude();
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // Main sequence: reset, then random back-to-back ops
    initial begin
        errors = 0; checked = 0; acc_m = 8'h00; z_m = 1'b0;
        sys_rst_in = 1'b1; op_valid_in = 1'b0; opcode_in = 16'h0000; t0_expire_in = 1'b0;
        for (int i = 0; i < 512; i++) ref_mem[i] = 8'(i * 8'h35);
        void'($urandom(32'h1427));
        repeat (4) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        check("acc_rst", {10'h000, acc_out}, 18'h00000);
        check("z_rst", {17'h0, zero_flag_out}, 18'h00000);
        check("wr_rst", mem_wr_out, 18'h00000);
        repeat (3000) begin
            k = $urandom % 7;
            a = 9'($urandom) & 9'h103;  // Few addresses, so hazards and address 0 recur
            lit = ($urandom % 2) ? acc_m : 8'($urandom);
            vld = (k != 6);
            case (k)
                0, 6: opcode_in = 16'h3800 | {7'h00, a};
                1: opcode_in = 16'h2200 | {7'h00, a};
                2: opcode_in = 16'h1A00 | {7'h00, a};
                3: opcode_in = 16'h1800 | {7'h00, a};
                4: opcode_in = {8'h7F, lit};
                default: opcode_in = 16'hC000 | {7'h00, a};
            endcase
            op_valid_in = vld;
            t0_expire_in = 1'($urandom);
            #1;
            check("addr", {9'h0, mem_addr_out}, {9'h0, opcode_in[8:0]});
            check("hit", {17'h0, op_hit_out}, {17'h0, vld && k < 5});
            check("clr", {17'h0, t0_presc_clr_out}, {17'h0, vld && k == 1 && a == 0});
            check("blk", {17'h0, t0_inc_block_out}, {17'h0, vld && k == 1 && a == 0 && t0_expire_in});
            v = ref_mem[opcode_in[8:0]];
            wr_m = '0;
            if (vld) begin
                case (k)
                    0: acc_m = {v[3:0], v[7:4]};
                    1: begin z_m = (v == 8'h00); wr_m = {1'b1, a, v}; end
                    2: begin v = v ^ acc_m; ref_mem[a] = v; z_m = (v == 8'h00); wr_m = {1'b1, a, v}; end
                    3: begin acc_m = acc_m ^ v; z_m = (acc_m == 8'h00); end
                    4: begin acc_m = acc_m ^ lit; z_m = (acc_m == 8'h00); end
                    default: ;
                endcase
            end
            @(negedge ref_clk_in);
            check("acc", {10'h000, acc_out}, {10'h000, acc_m});
            check("z", {17'h0, zero_flag_out}, {17'h0, z_m});
            check("wr", mem_wr_out, wr_m);
        end
        conclude();
    end
endmodule : tb
`default_nettype wire
